// *** rtl/fmtx_cfg_regs.sv ***
// audio, pilot and reference clock configuration bank of the fm transmitter
`timescale 1ns/1ps
// Functional notes
// - privacy bit one enables scramble and encryption
// - amplifier off after 58+code silent seconds, never for code 3
// - pilot deviation equals code percent of 75kHz
// - source field picks crystal or injected clock
// - oscillator drive is 6.25uA times code
// - frequency bit: zero 12MHz, one 24MHz
// - buffer gain 3+3*code-6*impedance code dB
// - reads return last written value or default
module fmtx_cfg_regs #(
    parameter int unsigned SEC_CYCLES = fmtx_pkg::FMTX_SEC_CYCLES
) (
    input wire logic CLOCK_I,
    input wire logic RST_I,
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_O,
    input wire logic AUDIO_DET_I,
    output logic PREEMPH_75US_O,
    output logic PRIVACY_EN_O,
    output logic PA_ON_O,
    output logic [13:0] PILOT_DEV_HZ_O,
    output logic XTAL_EN_O,
    output logic DIG_INJ_O,
    output logic SE_SINE_O,
    output logic DIFF_SINE_O,
    output logic [10:0] OSC_BIAS_QUA_O,
    output logic XTAL_24M_O,
    output logic signed [5:0] INBUF_GAIN_DB_O
);
    // stored register bytes and the handshake between slave and bank
    logic [7:0] pilot_reg; // audio_pilot_ctrl
    logic [7:0] xtl_reg; // ref_clock_ctrl
    logic [7:0] vga_reg; // input_gain_ctrl
    fmtx_pkg::fmtx_wr_s wr; // write strobe from the serial slave
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    // silence timer state: prescaler counts clocks, sec_reg counts seconds
    logic aud_m, aud_s; // audio detect synchroniser
    logic [25:0] presc_reg; // one-second prescaler
    logic [5:0] sec_reg; // silent seconds so far
    logic [1:0] silence_timeout_sel; // silence_timeout_sel
    logic [5:0] timeout_s;
    fmtx_pkg::fmtx_src_e src;

    // buffer gain in dB, signed, from gain and impedance codes
    function automatic logic signed [5:0] inbuf_gain(input logic [2:0] g, input logic [1:0] r);
        logic signed [6:0] sum;
        sum = 7'sd3 + 7'sd3 * $signed({4'h0, g}) - 7'sd6 * $signed({5'h0, r});
        return sum[5:0];
    endfunction

    // slave decodes the protocol and hands over one write at a time
    fmtx_i2c_slave u_slave (
        .clk_i(CLOCK_I),
        .rst_i(RST_I),
        .scl_i(SCL_I),
        .sda_i(SDA_I),
        .sda_oe_o(SDA_OE_O),
        .wr_o(wr),
        .rd_addr_o(rd_addr),
        .rd_data_i(rd_data)
    );

    // open-drain line: only ever pulled low
    assign SDA_O = 1'b0;

    // configuration registers, written only through the serial port
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            pilot_reg <= fmtx_pkg::FMTX_RST_PILOT;
            xtl_reg <= fmtx_pkg::FMTX_RST_XTL;
            vga_reg <= fmtx_pkg::FMTX_RST_VGA;
        end else if (wr.valid) begin
            // the pointer alone picks the target byte
            case (wr.addr)
                fmtx_pkg::FMTX_OFS_PILOT: pilot_reg <= wr.data;
                fmtx_pkg::FMTX_OFS_XTL: xtl_reg <= wr.data;
                fmtx_pkg::FMTX_OFS_VGA: vga_reg <= wr.data;
                default: begin
                    // writes elsewhere belong to other banks and are dropped
                end
            endcase
        end
    end

    // readback is the stored byte, so the host sees what it wrote
    always_comb begin
        case (rd_addr)
            fmtx_pkg::FMTX_OFS_PILOT: rd_data = pilot_reg;
            fmtx_pkg::FMTX_OFS_XTL: rd_data = xtl_reg;
            fmtx_pkg::FMTX_OFS_VGA: rd_data = vga_reg;
            default: rd_data = 8'h00;
        endcase
    end

    // field slices that feed the timer and the source decode
    assign silence_timeout_sel = pilot_reg[fmtx_pkg::FMTX_T1M_LSB +: 2];
    assign timeout_s = fmtx_pkg::FMTX_SILENCE_BASE_S + {4'h0, silence_timeout_sel};
    assign src = fmtx_pkg::fmtx_src_e'(xtl_reg[fmtx_pkg::FMTX_SRC_LSB +: 2]);

    // decoded analog and timing controls, all from flops
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            PREEMPH_75US_O <= 1'b0;
            PRIVACY_EN_O <= 1'b0;
            PILOT_DEV_HZ_O <= 14'h0000;
            {XTAL_EN_O, DIG_INJ_O, SE_SINE_O, DIFF_SINE_O} <= 4'h8;
            OSC_BIAS_QUA_O <= 11'h000;
            XTAL_24M_O <= 1'b1;
            INBUF_GAIN_DB_O <= 6'sh00;
        end else begin
            PREEMPH_75US_O <= pilot_reg[fmtx_pkg::FMTX_TC_BIT];
            PRIVACY_EN_O <= pilot_reg[fmtx_pkg::FMTX_PRIV_BIT];
            // pilot deviation in Hz: code percent of 75 kHz
            PILOT_DEV_HZ_O <= {10'h000, pilot_reg[fmtx_pkg::FMTX_PLT_LSB +: 4]}
                * {4'h0, fmtx_pkg::FMTX_PILOT_HZ_STEP};
            // exactly one source line is high, so the analog switches never fight
            XTAL_EN_O <= (src == fmtx_pkg::FMTX_SRC_XTAL);
            DIG_INJ_O <= (src == fmtx_pkg::FMTX_SRC_DIG);
            SE_SINE_O <= (src == fmtx_pkg::FMTX_SRC_SE_SINE);
            DIFF_SINE_O <= (src == fmtx_pkg::FMTX_SRC_DIFF_SINE);
            // bias in quarter microamps, so 6.25 uA steps stay exact
            OSC_BIAS_QUA_O <= {5'h00, xtl_reg[fmtx_pkg::FMTX_XISEL_LSB +: 6]}
                * {6'h00, fmtx_pkg::FMTX_OSC_QUA_STEP};
            XTAL_24M_O <= vga_reg[fmtx_pkg::FMTX_XSEL_BIT];
            INBUF_GAIN_DB_O <= inbuf_gain(vga_reg[fmtx_pkg::FMTX_GVGA_LSB +: 3],
                vga_reg[fmtx_pkg::FMTX_RIN_LSB +: 2]);
        end
    end

    // audio detector comes from the analog side, so synchronise it
    // level only: silence lasts seconds, so two cycles of delay do not matter
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            aud_m <= 1'b0;
            aud_s <= 1'b0;
        end else begin
            aud_m <= AUDIO_DET_I;
            aud_s <= aud_m;
        end
    end

    // silence timer; any audio restarts it and turns the amplifier back on
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            presc_reg <= 26'h0000000;
            sec_reg <= 6'h00;
            PA_ON_O <= 1'b1;
        end else if (aud_s) begin
            presc_reg <= 26'h0000000;
            sec_reg <= 6'h00;
            PA_ON_O <= 1'b1;
        end else if (silence_timeout_sel == fmtx_pkg::FMTX_TIMEOUT_NEVER) begin
            // shut-off disabled: hold the count where it is
            PA_ON_O <= 1'b1;
        end else if (sec_reg >= timeout_s) begin
            // count frozen here, so the amplifier stays off until audio or timeout code 3
            PA_ON_O <= 1'b0;
        end else if (presc_reg == 26'(SEC_CYCLES - 1)) begin
            // a full second of silence has passed
            presc_reg <= 26'h0000000;
            sec_reg <= sec_reg + 6'h01;
        end else begin
            presc_reg <= presc_reg + 26'h0000001;
        end
    end

    // checks kept next to the logic they guard
    priv_follow_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        (wr.valid && wr.addr == fmtx_pkg::FMTX_OFS_PILOT) |=> ##1
        (PRIVACY_EN_O == $past(wr.data[fmtx_pkg::FMTX_PRIV_BIT], 2)))
        else $error("privacy output does not follow written bit");
    // silence timer
    pa_off_when_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        $fell(PA_ON_O) |-> ($past(sec_reg) == 6'h3A + {4'h0, $past(silence_timeout_sel)})
        && $past(silence_timeout_sel) != 2'h3)
        else $error("amplifier switched off at wrong silence time");
    pa_never_off_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        (silence_timeout_sel == 2'h3) [*2] |-> PA_ON_O)
        else $error("amplifier off while shut-off disabled");
    pa_audio_on_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        aud_s |=> PA_ON_O && sec_reg == 6'h00)
        else $error("audio did not restore amplifier");
    // decoded outputs follow the byte held one cycle earlier
    pilot_dev_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        $stable(pilot_reg) |=> PILOT_DEV_HZ_O == 14'($past(pilot_reg[3:0]) * 750))
        else $error("pilot deviation mismatch");
    ref_onehot_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        $stable(xtl_reg) |=> $onehot({XTAL_EN_O, DIG_INJ_O, SE_SINE_O, DIFF_SINE_O})
        && (DIFF_SINE_O == ($past(xtl_reg[7:6]) == 2'b11))
        && (SE_SINE_O == ($past(xtl_reg[7:6]) == 2'b10)))
        else $error("reference source decode wrong");
    osc_bias_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        $stable(xtl_reg) |=> OSC_BIAS_QUA_O == 11'($past(xtl_reg[5:0]) * 25))
        else $error("oscillator bias mismatch");
    xtal_freq_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        $stable(vga_reg) |=> XTAL_24M_O == $past(vga_reg[7]))
        else $error("crystal frequency select mismatch");
    inbuf_gain_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        $stable(vga_reg) |=> INBUF_GAIN_DB_O
        == 6'(3 + 3 * int'($past(vga_reg[6:4])) - 6 * int'($past(vga_reg[1:0]))))
        else $error("input buffer gain mismatch");
    // storage and readback
    readback_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        (wr.valid && wr.addr >= 8'h02 && wr.addr <= 8'h04) ##1 (rd_addr == $past(wr.addr))
        |-> rd_data == $past(wr.data))
        else $error("readback differs from written value");
    reset_default_a: assert property (@(posedge CLOCK_I)
        RST_I |=> pilot_reg == 8'h29 && xtl_reg == 8'h10 && vga_reg == 8'hB2)
        else $error("registers not at default after reset");
    // a landed write, an amplifier that stays off, a second count that only steps or clears on audio
    write_lands_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        (wr.valid && wr.addr == fmtx_pkg::FMTX_OFS_XTL) |=> xtl_reg == $past(wr.data))
        else $error("write did not reach the register");
    pa_stays_off_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        (!PA_ON_O && !aud_s && silence_timeout_sel != 2'h3) |=> !PA_ON_O)
        else $error("amplifier came back without audio");
    sec_step_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
        $changed(sec_reg) |-> $past(aud_s) || sec_reg == $past(sec_reg) + 6'h01)
        else $error("silent second count jumped");
endmodule

// *** rtl/fmtx_i2c_slave.sv ***
// serial control slave: start/stop, address match, pointer, burst write and read
`timescale 1ns/1ps
module fmtx_i2c_slave (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_oe_o,
    output fmtx_pkg::fmtx_wr_s wr_o,
    output logic [7:0] rd_addr_o,
    input wire logic [7:0] rd_data_i
);
    logic scl_m, scl_s, scl_d; // synchroniser and edge stage
    logic sda_m, sda_s, sda_d;
    fmtx_pkg::fmtx_state_e state_reg;
    logic [3:0] cnt_reg; // bits seen in this byte
    logic [7:0] shift_reg; // received byte
    logic [7:0] tx_reg; // byte being sent
    logic [7:0] ptr_reg; // register pointer, auto-increments
    logic rw_reg;
    logic scl_rise, scl_fall, start_cond, stop_cond;

    // two flops before any logic, third flop only for edge detection
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {scl_m, scl_s, scl_d} <= 3'h7;
            {sda_m, sda_s, sda_d} <= 3'h7;
        end else begin
            {scl_m, scl_s, scl_d} <= {scl_i, scl_m, scl_s};
            {sda_m, sda_s, sda_d} <= {sda_i, sda_m, sda_s};
        end
    end

    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_cond = scl_s & scl_d & ~sda_d & sda_s;
    assign rd_addr_o = ptr_reg;

    // protocol engine; sda is only driven after a seen falling scl edge, and is released on start and stop too
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= fmtx_pkg::FMTX_ST_IDLE;
            cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            ptr_reg <= 8'h00;
            rw_reg <= 1'b0;
            sda_oe_o <= 1'b0;
            wr_o <= '0;
        end else begin
            wr_o.valid <= 1'b0;
            if (start_cond) begin
                // repeated start allowed anywhere
                state_reg <= fmtx_pkg::FMTX_ST_DEV;
                cnt_reg <= 4'h0;
                sda_oe_o <= 1'b0;
            end else if (stop_cond) begin
                state_reg <= fmtx_pkg::FMTX_ST_IDLE;
                sda_oe_o <= 1'b0;
            end else begin
                case (state_reg)
                    fmtx_pkg::FMTX_ST_DEV, fmtx_pkg::FMTX_ST_PTR, fmtx_pkg::FMTX_ST_WR: begin
                        if (scl_rise) begin
                            shift_reg <= {shift_reg[6:0], sda_s};
                            cnt_reg <= cnt_reg + 4'h1;
                        end else if (scl_fall && cnt_reg == 4'h8) begin
                            cnt_reg <= 4'h0;
                            sda_oe_o <= 1'b1;
                            if (state_reg == fmtx_pkg::FMTX_ST_DEV) begin
                                // foreign address: stay silent until next start
                                sda_oe_o <= (shift_reg[7:1] == fmtx_pkg::FMTX_DEV_ADDR);
                                rw_reg <= shift_reg[0];
                                state_reg <= (shift_reg[7:1] == fmtx_pkg::FMTX_DEV_ADDR) ?
                                    fmtx_pkg::FMTX_ST_DEV_ACK : fmtx_pkg::FMTX_ST_IDLE;
                            end else if (state_reg == fmtx_pkg::FMTX_ST_PTR) begin
                                ptr_reg <= shift_reg;
                                state_reg <= fmtx_pkg::FMTX_ST_PTR_ACK;
                            end else begin
                                wr_o <= '{valid: 1'b1, addr: ptr_reg, data: shift_reg};
                                state_reg <= fmtx_pkg::FMTX_ST_WR_ACK;
                            end
                        end
                    end
                    fmtx_pkg::FMTX_ST_DEV_ACK: begin
                        if (scl_fall) begin
                            cnt_reg <= 4'h0;
                            if (rw_reg) begin
                                tx_reg <= rd_data_i;
                                sda_oe_o <= ~rd_data_i[7];
                                state_reg <= fmtx_pkg::FMTX_ST_RD;
                            end else begin
                                sda_oe_o <= 1'b0;
                                state_reg <= fmtx_pkg::FMTX_ST_PTR;
                            end
                        end
                    end
                    fmtx_pkg::FMTX_ST_PTR_ACK, fmtx_pkg::FMTX_ST_WR_ACK: begin
                        if (scl_fall) begin
                            sda_oe_o <= 1'b0;
                            if (state_reg == fmtx_pkg::FMTX_ST_WR_ACK) begin
                                ptr_reg <= ptr_reg + 8'h01;
                            end
                            state_reg <= fmtx_pkg::FMTX_ST_WR;
                        end
                    end
                    fmtx_pkg::FMTX_ST_RD: begin
                        if (scl_rise) begin
                            cnt_reg <= cnt_reg + 4'h1;
                        end else if (scl_fall) begin
                            if (cnt_reg == 4'h8) begin
                                sda_oe_o <= 1'b0;
                                ptr_reg <= ptr_reg + 8'h01;
                                state_reg <= fmtx_pkg::FMTX_ST_RD_ACK;
                            end else begin
                                tx_reg <= {tx_reg[6:0], 1'b0};
                                sda_oe_o <= ~tx_reg[6];
                            end
                        end
                    end
                    fmtx_pkg::FMTX_ST_RD_ACK: begin
                        if (scl_rise && sda_s) begin
                            // master said no more bytes
                            state_reg <= fmtx_pkg::FMTX_ST_IDLE;
                        end else if (scl_fall) begin
                            tx_reg <= rd_data_i;
                            sda_oe_o <= ~rd_data_i[7];
                            cnt_reg <= 4'h0;
                            state_reg <= fmtx_pkg::FMTX_ST_RD;
                        end
                    end
                    default: begin
                        sda_oe_o <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule

// *** rtl/fmtx_pkg.sv ***
// shared constants, types and register layout of the transmitter configuration bank
package fmtx_pkg;
    // serial control slave address, 7 bits
    localparam logic [6:0] FMTX_DEV_ADDR = 7'h2C;
    // register offsets
    localparam logic [7:0] FMTX_OFS_PILOT = 8'h02;
    localparam logic [7:0] FMTX_OFS_XTL = 8'h03;
    localparam logic [7:0] FMTX_OFS_VGA = 8'h04;
    // values after reset
    localparam logic [7:0] FMTX_RST_PILOT = 8'h29;
    localparam logic [7:0] FMTX_RST_XTL = 8'h10;
    localparam logic [7:0] FMTX_RST_VGA = 8'hB2;
    // audio_pilot_ctrl field positions
    localparam int FMTX_TC_BIT = 7;
    localparam int FMTX_PRIV_BIT = 6;
    localparam int FMTX_T1M_LSB = 4;
    localparam int FMTX_PLT_LSB = 0;
    // ref_clock_ctrl field positions
    localparam int FMTX_SRC_LSB = 6;
    localparam int FMTX_XISEL_LSB = 0;
    // input_gain_ctrl field positions
    localparam int FMTX_XSEL_BIT = 7;
    localparam int FMTX_GVGA_LSB = 4;
    localparam int FMTX_RIN_LSB = 0;
    // silence shut-off timing
    localparam logic [5:0] FMTX_SILENCE_BASE_S = 6'h3A;
    localparam logic [1:0] FMTX_TIMEOUT_NEVER = 2'h3;
    localparam int FMTX_CLK_PERIOD_NS = 20;
    localparam int FMTX_SECOND_NS = 1_000_000_000;
    localparam int FMTX_SEC_CYCLES = FMTX_SECOND_NS / FMTX_CLK_PERIOD_NS;
    // scale factors of decoded analog settings
    localparam logic [9:0] FMTX_PILOT_HZ_STEP = 10'h2EE;
    localparam logic [4:0] FMTX_OSC_QUA_STEP = 5'h19;
    // reference clock source codes
    typedef enum logic [1:0] {
        FMTX_SRC_XTAL = 2'b00,
        FMTX_SRC_DIG = 2'b01,
        FMTX_SRC_SE_SINE = 2'b10,
        FMTX_SRC_DIFF_SINE = 2'b11
    } fmtx_src_e;
    // serial slave states
    typedef enum logic [3:0] {
        FMTX_ST_IDLE = 4'b0000,
        FMTX_ST_DEV = 4'b0001,
        FMTX_ST_DEV_ACK = 4'b0010,
        FMTX_ST_PTR = 4'b0011,
        FMTX_ST_PTR_ACK = 4'b0100,
        FMTX_ST_WR = 4'b0101,
        FMTX_ST_WR_ACK = 4'b0110,
        FMTX_ST_RD = 4'b0111,
        FMTX_ST_RD_ACK = 4'b1000
    } fmtx_state_e;
    // one register write from the serial slave
    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [7:0] data;
    } fmtx_wr_s;
endpackage

// *** sim/fmtx_cfg_regs_test.sv ***
// self-checking bench of the transmitter configuration bank
`timescale 1ns/1ps
module fmtx_cfg_regs_test;
    localparam int SEC = 10; // shortened second keeps the silence test short
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic audio = 1'b1;
    logic scl, host_oe, dut_oe, sdo; // bus pins
    wire sda = !(host_oe | (dut_oe & !sdo)); // pull-up wire, low while anyone drives
    logic priv, pa, xe, di, se, ds, x24, pre; // decoded outputs
    logic [13:0] pilot;
    logic [10:0] bias;
    logic signed [5:0] gain;
    logic [7:0] rdat;
    int miscompares = 0;
    int samples_checked = 0;

    fmtx_cfg_regs #(.SEC_CYCLES(SEC)) dut (
        .CLOCK_I(clk), .RST_I(rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(sdo),
        .SDA_OE_O(dut_oe), .AUDIO_DET_I(audio), .PREEMPH_75US_O(pre),
        .PRIVACY_EN_O(priv), .PA_ON_O(pa), .PILOT_DEV_HZ_O(pilot),
        .XTAL_EN_O(xe), .DIG_INJ_O(di), .SE_SINE_O(se), .DIFF_SINE_O(ds),
        .OSC_BIAS_QUA_O(bias), .XTAL_24M_O(x24), .INBUF_GAIN_DB_O(gain)
    );
    fmtx_host host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe));

    // free-running 50 MHz clock
    always #10 clk = ~clk;

    // compare with four-state equality so unknowns never match
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %0d seen %0d", what, e, g);
        end
    endtask
    // read a register back over the serial bus and compare
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, rdat);
        chk("readback", {24'h0, e}, {24'h0, rdat});
    endtask
    // defaults after reset, seen on the bus and at the decoded outputs
    task automatic t_reset();
        rdchk(fmtx_pkg::FMTX_OFS_PILOT, {4'h2, 4'h9});
        rdchk(fmtx_pkg::FMTX_OFS_XTL, {2'h0, 6'h10});
        rdchk(fmtx_pkg::FMTX_OFS_VGA, {1'h1, 3'h3, 2'h0, 2'h2});
        chk("privacy", 0, priv);
        chk("preemph", 0, pre);
        chk("pa on", 1, pa);
        chk("pilot", 9 * 750, pilot);
        chk("source", 4'h8, {xe, di, se, ds});
        chk("bias", 16 * 25, bias);
        chk("24m", 1, x24);
        chk("gain", 3 + 9 - 12, {{26{gain[5]}}, gain});
        $display("done reset");
    endtask
    // pilot codes 7 to 10, privacy toggled alongside
    task automatic t_pilot();
        logic [7:0] d;
        for (int p = 7; p <= 10; p++) begin
            d = {p[1], p[0], 2'h2, p[3:0]};
            host.wr(fmtx_pkg::FMTX_OFS_PILOT, d);
            chk("privacy", p[0], priv);
            chk("preemph", p[1], pre);
            chk("pilot", p * 750, pilot);
            rdchk(fmtx_pkg::FMTX_OFS_PILOT, d);
        end
        $display("done pilot");
    endtask
    // all four source codes with bias values up to full scale
    task automatic t_clock();
        logic [7:0] d;
        for (int s = 0; s < 4; s++) begin
            d = {s[1:0], 6'(s * 21)};
            host.wr(fmtx_pkg::FMTX_OFS_XTL, d);
            chk("source", 4'h8 >> s, {xe, di, se, ds});
            chk("bias", s * 21 * 25, bias);
            rdchk(fmtx_pkg::FMTX_OFS_XTL, d);
        end
        $display("done clock");
    endtask
    // gain table over buffer and impedance codes, frequency bit toggled
    task automatic t_gain();
        logic [7:0] d;
        for (int g = 0; g < 6; g++) begin
            for (int r = 0; r < 4; r++) begin
                d = {g[0], g[2:0], 2'h1, r[1:0]};
                host.wr(fmtx_pkg::FMTX_OFS_VGA, d);
                chk("gain", 3 + 3 * g - 6 * r, {{26{gain[5]}}, gain});
                chk("24m", g[0], x24);
                rdchk(fmtx_pkg::FMTX_OFS_VGA, d);
            end
        end
        $display("done gain");
    endtask
    // silence shut-off for each timeout code, then audio restores the amplifier
    task automatic t_silence();
        int n;
        int t;
        for (int s = 0; s < 4; s++) begin
            host.wr(fmtx_pkg::FMTX_OFS_PILOT, {2'h0, s[1:0], 4'h9});
            @(posedge clk);
            audio <= 1'b0;
            n = 0;
            t = (58 + s) * SEC;
            // bounded wait: the never code must outlast the longest timeout
            while (pa === 1'b1 && n < 700) begin
                @(posedge clk);
                n++;
            end
            if (s == 3) begin
                chk("pa kept", 1, pa);
            end else begin
                // window allows synchroniser delay and prescaler phase only
                chk("pa off window", 1, (n >= t - 9 && n <= t + 6));
                if (n >= 700) begin
                    end_of_test();
                end
            end
            audio <= 1'b1;
            repeat (6) @(posedge clk);
            chk("pa back", 1, pa);
        end
        $display("done silence");
    endtask
    // single closing point of the run
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // main sequence: reset, then each scenario in turn
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_pilot();
        t_clock();
        t_gain();
        t_silence();
        end_of_test();
    end
endmodule

// *** sim/fmtx_host.sv ***
// host-side serial control master model for the configuration bank
`timescale 1ns/1ps
module fmtx_host (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_o
);
    // idle bus: clock high, data released to the pull-up
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    // half bit period, above the 4-clock minimum so the synchronisers keep up
    task automatic half();
        repeat (5) @(posedge clk_i);
    endtask
    // one clock pulse; data is sampled at the end of the high phase
    task automatic pulse(output logic s);
        half();
        scl_o <= 1'b1;
        half();
        s = sda_i;
        scl_o <= 1'b0;
        half();
    endtask
    // start or repeated start: data falls while the clock is high
    task automatic start();
        sda_oe_o <= 1'b0;
        half();
        scl_o <= 1'b1;
        half();
        sda_oe_o <= 1'b1;
        half();
        scl_o <= 1'b0;
        half();
    endtask
    // stop: data rises while the clock is high
    task automatic stop();
        sda_oe_o <= 1'b1;
        half();
        scl_o <= 1'b1;
        half();
        sda_oe_o <= 1'b0;
        half();
    endtask
    // byte out, msb first, then release for the acknowledge slot
    task automatic byte_w(input logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            sda_oe_o <= !b[i];
            pulse(s);
        end
        sda_oe_o <= 1'b0;
        pulse(s);
    endtask
    // byte in, then a not-acknowledge to end the read
    task automatic byte_r(output logic [7:0] b);
        logic s;
        sda_oe_o <= 1'b0;
        for (int i = 7; i >= 0; i--) begin
            pulse(s);
            b[i] = s;
        end
        pulse(s);
    endtask
    // single register write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        start();
        byte_w({fmtx_pkg::FMTX_DEV_ADDR, 1'b0});
        byte_w(a);
        byte_w(d);
        stop();
    endtask
    // pointer write, repeated start, single byte read
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        start();
        byte_w({fmtx_pkg::FMTX_DEV_ADDR, 1'b0});
        byte_w(a);
        start();
        byte_w({fmtx_pkg::FMTX_DEV_ADDR, 1'b1});
        byte_r(d);
        stop();
    endtask
endmodule
